/* common/tx_ctrl_params.svh */
// Purpose: constants for the transmit character control and enable latches
// Assumes: 40 MHz system clock
// Notes:   timing counts derived from printed times
// Functional notes
// - In the no-select encoding mode the special-code select input is ignored.
// - Unbonded control 00 data, 01 fill, 10 special, 11 word sync.
// - Unbonded word sync starts only when both control bits sampled high; runs 16 uninterrupted.
// - Sync is 16 fill symbols; 2nd and 3rd reversed disparity; inputs ignored.
// - Start condition seen at sequence end restarts it for 16 more characters.
// - Start character must have odd parity when checking; next 15 unchecked.
// - Bonding select high joins channels A and B into one path.
// - Bonded, B bit0 low: channel A follows A bit1 and A bit0.
// - Bonded, B bit0 low: channel B follows B bit1 with A bit0.
// - Bonded, B bit0 high starts word sync on both channels, parity permitting.
// - Each channel can run a repeating 511-character pseudo-random self-test.
// - Receive clock select off middle and encoder on: sync precedes each pass.
// - Self-test latch enable high: low enable input turns on mapped self-test.
// - Latch enable falling captures all four enables until it rises again.
// - Enable 3 tx B/out B2, 2 rx B/out B1, 1 tx A/out A2, 0 rx A/out A1.
// - Device reset presets self-test latch so all self-tests are off.
// - Self-test active ignores that channel's data byte and control inputs.
// - Local loopback makes every enabled driver output static logic one.
// - Output latch enable high passes enables; falling holds them until rise.
// - Both outputs of a channel disabled powers down its transmit logic.
// - Device reset clears the output enable latch, disabling all drivers.
// - Re-enabling after all channels off flags a 200 us settling period.
`ifndef TX_CTRL_PARAMS_SVH
`define TX_CTRL_PARAMS_SVH
`define CLK_MHZ          40
`define SYNC_LEN         16
`define SYNC_LAST        4'hF
`define LFSR_PERIOD      511
`define LFSR_SEED        9'h1FF
`define SETTLE_US        200
`define SETTLE_CYCLES    (`SETTLE_US * `CLK_MHZ)
`define K28_5            8'hBC
`define MODE_NOSEL       3'h5
`define TSEL_MID         2'h1
`define EN_RXA           0
`define EN_TXA           1
`define EN_RXB           2
`define EN_TXB           3
`endif

/* common/tx_ctrl_pkg.sv */
// Purpose: types for the transmit character control block
// Assumes: tx_ctrl_params.svh holds the numbers
// Notes:   none
package tx_ctrl_pkg;
	typedef enum logic [1:0]
	{
		CH_DATA    = 2'b00,
		CH_FILL    = 2'b01,
		CH_SPECIAL = 2'b10,
		CH_SYNC    = 2'b11
	} char_kind_e;
	typedef enum logic [1:0]
	{
		DISP_NORMAL  = 2'b00,
		DISP_REVERSE = 2'b01,
		DISP_NONE    = 2'b10
	} disp_ctl_e;
	typedef struct packed
	{
		logic       valid;
		logic       is_k;
		logic [7:0] byte_val;
		disp_ctl_e  disp;
	} tx_char_s;
	typedef struct packed
	{
		logic [1:0] ctl;
		logic [7:0] data;
		logic       parity;
	} tx_in_s;
endpackage

/* logic/selftest_lfsr.sv */
// Purpose: 9-bit pattern generator for one transmit channel
// Assumes: run_in held low during each preamble
// Notes:   k flag from state bit 8, also a feedback tap, covers special codes
`timescale 1ns/1ps
`include "tx_ctrl_params.svh"
module selftest_lfsr
(
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       run_in,
	output logic [8:0]      state_out,
	output logic            wrap_out
);
	logic [8:0] lfsr_r;
	logic [8:0] lfsr_nxt;
	always_comb
	begin
		lfsr_nxt = lfsr_r;
		if (!run_in)
			lfsr_nxt = `LFSR_SEED;
		else
			lfsr_nxt = {lfsr_r[7:0], lfsr_r[8] ^ lfsr_r[4]};
	end
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			lfsr_r <= `LFSR_SEED;
		else
			lfsr_r <= lfsr_nxt;
	end
	assign state_out = lfsr_r;
	assign wrap_out  = run_in && (lfsr_nxt == `LFSR_SEED);
	chk_lfsr_nonzero: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		lfsr_r != 9'h000) else $error("lfsr locked at zero");
endmodule

/* logic/enable_latch.sv */
// Purpose: four-bit transparent-high enable latch, clocked form
// Assumes: latch enable synchronous to clock
// Notes:   reset value is a parameter
`timescale 1ns/1ps
module enable_latch #(
	parameter logic [3:0] RESET_VAL = 4'h0
)
(
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       open_in,
	input  wire logic [3:0] d_in,
	output logic [3:0]      q_out
);
	logic [3:0] q_r;
	logic [3:0] q_nxt;
	always_comb
	begin
		q_nxt = open_in ? d_in : q_r;
	end
	always_ff @(posedge sys_clk_in or posedge rst_in)
	begin
		if (rst_in)
			q_r <= RESET_VAL;
		else
			q_r <= q_nxt;
	end
	assign q_out = open_in ? d_in : q_r;
	chk_latch_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!open_in && !$past(open_in) |-> $stable(q_r)) else $error("latch moved while closed");
endmodule

/* logic/tx_char_control.sv */
// Purpose: transmit character selection, word sync, self-test and driver enables
// Assumes: inputs synchronous to sys_clk_in, one character per clock
// Notes:   device_reset_n and rst_in both reset the latches
`timescale 1ns/1ps
`include "tx_ctrl_params.svh"
module tx_char_control
	import tx_ctrl_pkg::*;
#(
	parameter int SETTLE_CYCLES = `SETTLE_CYCLES
)
(
	input  wire logic              sys_clk_in,
	input  wire logic              rst_in,
	input  wire logic              device_reset_n_in,
	input  wire logic [2:0]        tx_encode_select_in,
	input  wire logic              special_code_select_in,
	input  wire logic              rx_bonding_select_in,
	input  wire logic [1:0]        rx_clock_source_select_in,
	input  wire logic              parity_check_en_in,
	input  wire tx_ctrl_pkg::tx_in_s tx_char_a_in,
	input  wire tx_ctrl_pkg::tx_in_s tx_char_b_in,
	input  wire logic [3:0]        shared_enable_inputs_in,
	input  wire logic              selftest_latch_enable_in,
	input  wire logic              output_latch_enable_in,
	input  wire logic              local_loopback_enable_in,
	output tx_ctrl_pkg::tx_char_s  tx_out_a_out,
	output tx_ctrl_pkg::tx_char_s  tx_out_b_out,
	output logic [3:0]             driver_enable_out,
	output logic [3:0]             driver_static_one_out,
	output logic [1:0]             tx_logic_power_out,
	output logic [3:0]             selftest_enable_out,
	output logic [1:0]             rx_pll_enable_out,
	output logic                   settling_out
);
	import tx_ctrl_pkg::*;

	logic       rst_all;
	logic [3:0] st_latch;
	logic [3:0] oe_latch;
	logic [8:0] lfsr_a;
	logic [8:0] lfsr_b;
	logic       wrap_a;
	logic       wrap_b;
	logic [1:0] st_run;

	assign rst_all = rst_in | ~device_reset_n_in;

	// separate latches on the shared enables
	enable_latch #(.RESET_VAL(4'hF)) u_st_latch
	(
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_all),
		.open_in    (selftest_latch_enable_in),
		.d_in       (shared_enable_inputs_in),
		.q_out      (st_latch)
	);
	enable_latch #(.RESET_VAL(4'h0)) u_oe_latch
	(
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_all),
		.open_in    (output_latch_enable_in),
		.d_in       (shared_enable_inputs_in),
		.q_out      (oe_latch)
	);

	function automatic logic odd_ok(input tx_in_s c);
		odd_ok = ^{c.ctl, c.data, c.parity};
	endfunction

	function automatic tx_char_s make_char(input char_kind_e k, input logic [7:0] d);
		make_char = '{valid: 1'b1, is_k: (k != CH_DATA), byte_val: d, disp: DISP_NORMAL};
		if (k == CH_FILL || k == CH_SYNC)
			make_char.byte_val = `K28_5;
	endfunction

	logic       mode5;
	logic       bonded;
	char_kind_e kind_a;
	char_kind_e kind_b;
	assign mode5  = (tx_encode_select_in == `MODE_NOSEL);
	assign bonded = rx_bonding_select_in;
	assign st_run = {~st_latch[`EN_TXB], ~st_latch[`EN_TXA]};

	always_comb
	begin
		if (bonded && tx_char_b_in.ctl[0])
		begin
			kind_a = CH_SYNC;
			kind_b = CH_SYNC;
		end
		else if (bonded)
		begin
			kind_a = char_kind_e'({tx_char_a_in.ctl[1], tx_char_a_in.ctl[0]});
			kind_b = char_kind_e'({tx_char_b_in.ctl[1], tx_char_a_in.ctl[0]});
		end
		else
		begin
			kind_a = char_kind_e'(tx_char_a_in.ctl);
			kind_b = char_kind_e'(tx_char_b_in.ctl);
		end
	end

	// per-channel sync counter and output
	logic [3:0] cnt_r   [2];
	logic [3:0] cnt_nxt [2];
	logic [1:0] busy_r;
	logic [1:0] busy_nxt;
	logic [1:0] pre_r;
	logic [1:0] pre_nxt;
	logic [1:0] st_prev_r;
	logic [1:0] st_prev_nxt;
	tx_char_s   out_r   [2];
	tx_char_s   out_nxt [2];
	logic [8:0] lfsr_v  [2];
	logic [1:0] wrap_v;
	logic [1:0] need_pre;

	assign lfsr_v[0] = lfsr_a;
	assign lfsr_v[1] = lfsr_b;
	assign wrap_v    = {wrap_b, wrap_a};
	assign need_pre  = {2{(rx_clock_source_select_in != `TSEL_MID)
		&& tx_encode_select_in[2:1] != 2'b00}};

	selftest_lfsr u_lfsr_a
	(
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_all),
		.run_in     (st_run[0] && !(busy_r[0] && pre_r[0])),
		.state_out  (lfsr_a),
		.wrap_out   (wrap_a)
	);
	selftest_lfsr u_lfsr_b
	(
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_all),
		.run_in     (st_run[1] && !(busy_r[1] && pre_r[1])),
		.state_out  (lfsr_b),
		.wrap_out   (wrap_b)
	);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : gen_ch
			tx_in_s     in_c;
			char_kind_e k_c;
			assign in_c = (g == 0) ? tx_char_a_in : tx_char_b_in;
			assign k_c  = (g == 0) ? kind_a : kind_b;
			always_comb
			begin
				cnt_nxt[g]  = cnt_r[g];
				busy_nxt[g] = busy_r[g];
				pre_nxt[g]  = pre_r[g];
				st_prev_nxt[g] = st_run[g];
				out_nxt[g]  = make_char(CH_DATA, in_c.data);
				if (busy_r[g])
				begin
					// inputs ignored mid-sequence, no parity check
					out_nxt[g] = make_char(CH_SYNC, 8'h00);
					if (cnt_r[g] == 4'h1 || cnt_r[g] == 4'h2)
						out_nxt[g].disp = DISP_REVERSE;
					cnt_nxt[g] = cnt_r[g] + 4'h1;
					if (cnt_r[g] == `SYNC_LAST)
					begin
						busy_nxt[g] = 1'b0;
						pre_nxt[g]  = 1'b0;
					end
				end
				else if (st_run[g])
				begin
					// self-test replaces host data
					out_nxt[g] = '{valid: 1'b1, is_k: lfsr_v[g][8],
						byte_val: lfsr_v[g][7:0], disp: DISP_NORMAL};
					// preamble at the start of a pass and at every wrap
					if (need_pre[g] && (wrap_v[g] || !st_prev_r[g]))
					begin
						busy_nxt[g] = 1'b1;
						pre_nxt[g]  = 1'b1;
						cnt_nxt[g]  = 4'h1;
						out_nxt[g]  = make_char(CH_SYNC, 8'h00);
					end
				end
				else if (mode5 && k_c == CH_SYNC)
				begin
					if (!parity_check_en_in || odd_ok(in_c))
					begin
						busy_nxt[g] = 1'b1;
						cnt_nxt[g]  = 4'h1;
						out_nxt[g]  = make_char(CH_SYNC, 8'h00);
					end
					else
						out_nxt[g].valid = 1'b0;
				end
				else
					out_nxt[g] = make_char(k_c, in_c.data);
			end
			always_ff @(posedge sys_clk_in or posedge rst_all)
			begin
				if (rst_all)
				begin
					cnt_r[g]  <= 4'h0;
					busy_r[g] <= 1'b0;
					pre_r[g]  <= 1'b0;
					st_prev_r[g] <= 1'b0;
					out_r[g]  <= '0;
				end
				else
				begin
					cnt_r[g]  <= cnt_nxt[g];
					busy_r[g] <= busy_nxt[g];
					pre_r[g]  <= pre_nxt[g];
					st_prev_r[g] <= st_prev_nxt[g];
					out_r[g]  <= out_nxt[g];
				end
			end
		end
	endgenerate

	// driver enables, loopback, power and settling
	logic [3:0]  drv_en_r;
	logic [3:0]  one_r;
	logic [1:0]  pwr_r;
	logic [3:0]  st_en_r;
	logic [1:0]  rxpll_r;
	logic        settle_r;
	logic [15:0] settle_cnt_r;
	logic [3:0]  drv_en_nxt;
	logic [3:0]  one_nxt;
	logic [1:0]  pwr_nxt;
	logic        settle_nxt;
	logic [15:0] settle_cnt_nxt;

	always_comb
	begin
		drv_en_nxt     = oe_latch;
		one_nxt        = local_loopback_enable_in ? oe_latch : 4'h0;
		pwr_nxt        = {|oe_latch[3:2], |oe_latch[1:0]};
		settle_nxt     = settle_r;
		settle_cnt_nxt = settle_cnt_r;
		if (drv_en_r == 4'h0 && oe_latch != 4'h0)
		begin
			settle_nxt     = 1'b1;
			settle_cnt_nxt = 16'(SETTLE_CYCLES - 1);
		end
		else if (settle_r)
		begin
			if (settle_cnt_r == 16'h0000)
				settle_nxt = 1'b0;
			else
				settle_cnt_nxt = settle_cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_all)
	begin
		if (rst_all)
		begin
			drv_en_r     <= 4'h0;
			one_r        <= 4'h0;
			pwr_r        <= 2'h0;
			st_en_r      <= 4'h0;
			rxpll_r      <= 2'h0;
			settle_r     <= 1'b0;
			settle_cnt_r <= 16'h0000;
		end
		else
		begin
			drv_en_r     <= drv_en_nxt;
			one_r        <= one_nxt;
			pwr_r        <= pwr_nxt;
			st_en_r      <= ~st_latch;
			rxpll_r      <= {oe_latch[`EN_RXB], oe_latch[`EN_RXA]};
			settle_r     <= settle_nxt;
			settle_cnt_r <= settle_cnt_nxt;
		end
	end

	assign tx_out_a_out          = out_r[0];
	assign tx_out_b_out          = out_r[1];
	assign driver_enable_out     = drv_en_r;
	assign driver_static_one_out = one_r;
	assign tx_logic_power_out    = pwr_r;
	assign selftest_enable_out   = st_en_r;
	assign rx_pll_enable_out     = rxpll_r;
	assign settling_out          = settle_r;

	chk_sync_length: assert property (@(posedge sys_clk_in) disable iff (rst_all)
		$rose(busy_r[0]) |-> busy_r[0] [*8] ##1 busy_r[0] [*7]) else $error("sync short");
	chk_sync_reverse: assert property (@(posedge sys_clk_in) disable iff (rst_all)
		busy_r[0] && cnt_r[0] == 4'h1 |=> out_r[0].disp == DISP_REVERSE)
		else $error("disparity not reversed");
	chk_sync_fill: assert property (@(posedge sys_clk_in) disable iff (rst_all)
		busy_r[1] |=> out_r[1].byte_val == `K28_5) else $error("sync not fill");
	chk_bond_both: assert property (@(posedge sys_clk_in) disable iff (rst_all)
		mode5 && bonded && tx_char_b_in.ctl[0] && !busy_r[0] && !busy_r[1] && st_run == 2'b00
		&& !parity_check_en_in |=> busy_r == 2'b11) else $error("bonded sync missing");
	chk_parity_block: assert property (@(posedge sys_clk_in) disable iff (rst_all)
		mode5 && !busy_r[0] && st_run[0] == 1'b0 && parity_check_en_in && !odd_ok(tx_char_a_in)
		|=> !busy_r[0]) else $error("bad parity started sync");
	chk_loop_one: assert property (@(posedge sys_clk_in) disable iff (rst_all)
		local_loopback_enable_in |=> driver_static_one_out == $past(oe_latch))
		else $error("loopback drive wrong");
	chk_power_down: assert property (@(posedge sys_clk_in) disable iff (rst_all)
		drv_en_r[1:0] == 2'b00 |-> pwr_r[0] == 1'b0) else $error("channel a powered");
	chk_settle_flag: assert property (@(posedge sys_clk_in) disable iff (rst_all)
		drv_en_r == 4'h0 && oe_latch != 4'h0 |=> settle_r) else $error("no settling");
	cov_sync: cover property (@(posedge sys_clk_in) $rose(busy_r[0]));
	cov_bonded: cover property (@(posedge sys_clk_in) bonded && busy_r == 2'b11);
	cov_selftest: cover property (@(posedge sys_clk_in) st_run[1] && wrap_b);
endmodule

/* sim/host_char_source.sv */
// Purpose: host model forming the parallel characters of both channels
// Assumes: one clock, both channels launched on the same edge
// Notes:   parity kept odd unless told to break channel A parity
`timescale 1ns/1ps
module host_char_source
(
	input  wire logic                break_parity_in,
	input  wire logic [1:0]          ctl_a_in,
	input  wire logic [1:0]          ctl_b_in,
	input  wire logic [7:0]          data_a_in,
	input  wire logic [7:0]          data_b_in,
	output tx_ctrl_pkg::tx_in_s      char_a_out,
	output tx_ctrl_pkg::tx_in_s      char_b_out
);
	import tx_ctrl_pkg::*;
	// each half follows only its own ctl and data inputs; channel A also follows break_parity_in
	assign char_a_out = {ctl_a_in, data_a_in, ~^{ctl_a_in, data_a_in} ^ break_parity_in};
	assign char_b_out = {ctl_b_in, data_b_in, ~^{ctl_b_in, data_b_in}};
endmodule

/* sim/test_tx_char_control.sv */
// Purpose: self-checking bench for the transmit character control block
// Assumes: settling count shortened to 20 cycles
// Notes:   random data from a bench shift register
`timescale 1ns/1ps
`include "tx_ctrl_params.svh"
module test_tx_char_control;
	import tx_ctrl_pkg::*;
	logic        sys_clk_in, rst_in, dev_n, scs, bond, par_en, brk, ble, ole, lpe, settle;
	logic [2:0]  mode;
	logic [1:0]  rxck, ca, cb, pwr, pll;
	logic [7:0]  da, db, xa, xb;
	logic [3:0]  sh, drv, st1, ste;
	logic [31:0] lfsr_r;
	logic [8:0]  pat [0:539];
	tx_in_s      ia, ib;
	tx_char_s    oa, ob;
	int          mismatches, comparisons, n;
	host_char_source u_host_char_source (.break_parity_in(brk), .ctl_a_in(ca), .ctl_b_in(cb),
		.data_a_in(da), .data_b_in(db), .char_a_out(ia), .char_b_out(ib));
	tx_char_control #(.SETTLE_CYCLES(20)) u_tx_char_control (.sys_clk_in(sys_clk_in),
		.rst_in(rst_in), .device_reset_n_in(dev_n), .tx_encode_select_in(mode),
		.special_code_select_in(scs), .rx_bonding_select_in(bond),
		.rx_clock_source_select_in(rxck), .parity_check_en_in(par_en), .tx_char_a_in(ia),
		.tx_char_b_in(ib), .shared_enable_inputs_in(sh), .selftest_latch_enable_in(ble),
		.output_latch_enable_in(ole), .local_loopback_enable_in(lpe), .tx_out_a_out(oa),
		.tx_out_b_out(ob), .driver_enable_out(drv), .driver_static_one_out(st1),
		.tx_logic_power_out(pwr), .selftest_enable_out(ste), .rx_pll_enable_out(pll),
		.settling_out(settle));
	initial
	begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end
	function automatic logic [7:0] rnd8();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		return lfsr_r[7:0];
	endfunction
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_char(input tx_char_s got, input logic [1:0] kind, input logic [7:0] d);
		comparisons++;
		if (got.valid !== 1'b1 || got.is_k !== (kind != 2'b00)
			|| (kind != 2'b10 && got.byte_val !== ((kind == 2'b00) ? d : `K28_5)))
		begin
			mismatches++;
			$display("wrong value at %0t got %h exp %h", $time, got, {kind, d});
		end
	endtask
	task automatic drive(input logic [1:0] a, input logic [1:0] b);
		@(posedge sys_clk_in);
		xa = rnd8();
		xb = rnd8();
		ca <= a;
		cb <= b;
		da <= xa;
		db <= xb;
		scs <= lfsr_r[9];
	endtask
	task automatic step(input logic [1:0] a, b, ka, kb);
		drive(a, b);
		@(posedge sys_clk_in);
		#1;
		chk_char(oa, ka, xa);
		chk_char(ob, kb, xb);
		if (ka == 2'b11 || kb == 2'b11)
		begin
			drive(2'b00, 2'b00);
			repeat (16) @(posedge sys_clk_in);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk_in);
		#1;
	endtask
	initial
	begin
		#(25 * 20000);
		mismatches++;
		tally_and_finish();
	end
	initial
	begin
		lfsr_r = 32'h7612;
		{rst_in, dev_n, mode, rxck, sh} = {2'b11, `MODE_NOSEL, 2'h1, 4'hF};
		{scs, bond, par_en, brk, ble, ole, lpe, ca, cb, da, db} = '0;
		repeat (6) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		cyc(1);
		chk_vec(9'(ste), 9'h000);
		chk_vec(9'(drv), 9'h000);
		for (int k = 0; k < 4; k++)
			step(2'(k), 2'(3 - k), 2'(k), 2'(3 - k));
		drive(2'b11, 2'b00);
		for (n = 1; n <= 33; n++)
		begin
			@(posedge sys_clk_in);
			if (n == 17)
				ca <= 2'b00;
			#1;
			if (n <= 32)
				chk_char(oa, 2'b11, xa);
			if (n == 2 || n == 3 || n == 18 || n == 19)
				chk_vec(9'(oa.disp), 9'(DISP_REVERSE));
		end
		chk_char(oa, 2'b00, xa);
		@(posedge sys_clk_in);
		par_en <= 1'b1;
		brk <= 1'b1;
		drive(2'b11, 2'b00);
		@(posedge sys_clk_in);
		brk <= 1'b0;
		ca <= 2'b00;
		#1;
		chk_vec(9'(oa.valid), 9'h000);
		step(2'b11, 2'b00, 2'b11, 2'b00);
		bond <= 1'b1;
		for (int i = 0; i < 8; i++)
			step({i[0], i[1]}, {i[2], 1'b0}, {i[0], i[1]}, {i[2], i[1]});
		step({lfsr_r[3], lfsr_r[4]}, {lfsr_r[5], 1'b1}, 2'b11, 2'b11);
		@(posedge sys_clk_in);
		{bond, par_en, ole, sh} <= {3'b001, 4'h0};
		cyc(3);
		chk_vec(9'(drv), 9'h000);
		chk_vec(9'(pwr), 9'h000);
		@(posedge sys_clk_in);
		sh <= 4'b0010;
		n = 0;
		while (settle !== 1'b1 && n < 6)
		begin
			cyc(1);
			n++;
		end
		if (n >= 6)
		begin
			mismatches++;
			tally_and_finish();
		end
		chk_vec(9'(drv), 9'h002);
		chk_vec(9'(pwr), 9'h001);
		n = 0;
		while (settle === 1'b1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		if (n >= 40)
		begin
			mismatches++;
			tally_and_finish();
		end
		chk_vec(9'(n >= 19 && n <= 22), 9'h001);
		@(posedge sys_clk_in);
		{sh, lpe} <= {4'b1100, 1'b1};
		cyc(3);
		chk_vec(9'(st1), 9'h00C);
		chk_vec(9'(pwr), 9'h002);
		chk_vec(9'(pll), 9'h002);
		@(posedge sys_clk_in);
		{ole, sh, lpe} <= {1'b0, 4'h3, 1'b0};
		cyc(3);
		chk_vec(9'(drv), 9'h00C);
		@(posedge sys_clk_in);
		{ble, sh} <= {1'b1, 4'b0101};
		cyc(3);
		chk_vec(9'(ste), 9'h00A);
		chk_vec(9'(drv), 9'h00C);
		@(posedge sys_clk_in);
		ble <= 1'b0;
		sh <= 4'(rnd8());
		cyc(3);
		chk_vec(9'(ste), 9'h00A);
		for (int i = 0; i < 540; i++)
		begin
			drive(lfsr_r[2:1], lfsr_r[4:3]);
			#1;
			pat[i] = {oa.is_k, oa.byte_val};
		end
		for (int i = 10; i < 29; i++)
			chk_vec(pat[i + 511], pat[i]);
		@(posedge sys_clk_in);
		{ble, sh, rxck, ca, cb} <= {1'b1, 4'hF, 2'h0, 4'h0};
		cyc(4);
		@(posedge sys_clk_in);
		sh <= 4'b1101;
		n = 0;
		for (int i = 0; i < 30; i++)
		begin
			cyc(1);
			n = (oa.is_k === 1'b1 && oa.byte_val === `K28_5) ? n + 1 : ((n >= 16) ? n : 0);
		end
		chk_vec(9'(n >= 16), 9'h001);
		@(posedge sys_clk_in);
		{dev_n, ble} <= 2'b00;
		cyc(2);
		chk_vec(9'(ste), 9'h000);
		chk_vec(9'(drv), 9'h000);
		dev_n <= 1'b1;
		cyc(2);
		chk_vec(9'(ste), 9'h000);
		chk_vec(9'(drv), 9'h000);
		tally_and_finish();
	end
endmodule
